// [bench/pgh_checker.sv]
// Link assertions for group 0 between device and peripheral ends
module pgh_checker
  import pgh_pkg::*;
(
  input wire logic                         clk_i,
  input wire logic                         rst_b_i,
  input wire logic [NGRP-1:0]              req,
  input wire logic [NGRP-1:0]              dev_req_oe_b,
  input wire logic [NGRP-1:0]              dev_ack,
  input wire logic [NPORT-1:0][PORT_W-1:0] dev_data,
  input wire logic [NPORT-1:0]             dev_data_oe_b,
  input wire logic                         per_req_oe_b,
  input wire logic [NPORT-1:0]             per_data_oe_b
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);

  // Peripheral strobe falls while the device shows ready
  sequence s_strobe_fall;
    !per_req_oe_b && $fell(req[0]) && !dev_ack[0];
  endsequence
  sequence s_ack_release;
    ##[1:4] dev_ack[0];
  endsequence

  a_int_low_len: assert property (!dev_req_oe_b[0] && $fell(req[0])
    |-> (!req[0])[*3] ##1 req[0]) else $error("Request low length wrong");
  a_int_high_min: assert property (!dev_req_oe_b[0] && $rose(req[0])
    |-> req[0][*3]) else $error("Request period too short");
  a_ext_high_min: assert property (!per_req_oe_b && $rose(req[0])
    |-> req[0][*2]) else $error("Peripheral request high too short");
  a_ack_off_fall: assert property (s_strobe_fall |-> s_ack_release)
    else $error("Acknowledge not released after strobe");
  a_ack_wait_rise: assert property (!per_req_oe_b && !req[0]
    && dev_ack[0] |=> dev_ack[0]) else $error("Acknowledge before rise");
  a_out_data_hold: assert property (!dev_data_oe_b[0] && !dev_ack[0]
    |=> $stable(dev_data[0])) else $error("Output data moved");
  a_req_one_drv: assert property (dev_req_oe_b[0] || per_req_oe_b)
    else $error("Request driven by both ends");
  a_data_one_drv: assert property (&(dev_data_oe_b | per_data_oe_b))
    else $error("Data driven by both ends");
endmodule : pgh_checker

// [bench/tb_pattern_gen_handshake.sv]
// Testbench joining the device and peripheral ends over the link
module tb_pattern_gen_handshake;
  import pgh_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic                        clk_i, rst_b_i, prv_or;
  pgh_cfg_s [NGRP-1:0]         cfg;
  pgh_cfg_s                    c;
  logic [NGRP-1:0]             go, ovl, ordy, ivl, busy, done;
  logic [NGRP-1:0][DATA_W-1:0] owd, iwd;
  logic                        hs, dout, wack, dreq, rgo, beg, endp;
  logic                        svl, srdy, rvl, pbusy;
  logic [DATA_W-1:0]           swd, rwd, in_w, rcv_w, out_d;
  int                          n_in, n_out, n_rcv, n_done, gap, last, cyc;
  int                          err_count, total_checks;
  int                          n_sent;
  logic [NPORT-1:0]            pgrp;

  pgh_link_if #(.PGRP(0)) link ();
  pgh_dev pgh_dev_inst (.clk_i(clk_i), .rst_b_i(rst_b_i), .link(link),
    .cfg_i(cfg), .port_grp_i(pgrp), .go_i(go), .out_word_i(owd),
    .out_valid_i(ovl), .out_ready_o(ordy), .in_word_o(iwd),
    .in_valid_o(ivl), .busy_o(busy), .done_o(done));
  pgh_per pgh_per_inst (.clk_i(clk_i), .rst_b_i(rst_b_i), .link(link),
    .hs_mode_i(hs), .dir_out_i(dout), .wait_ack_i(wack),
    .drive_req_i(dreq), .req_go_i(rgo), .begin_i(beg), .end_i(endp),
    .send_word_i(swd), .send_valid_i(svl), .send_ready_o(srdy),
    .rcv_word_o(rwd), .rcv_valid_o(rvl), .busy_o(pbusy));
  pgh_checker pgh_checker_inst (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .req(link.req), .dev_req_oe_b(link.dev_req_oe_b),
    .dev_ack(link.dev_ack), .dev_data(link.dev_data),
    .dev_data_oe_b(link.dev_data_oe_b), .per_req_oe_b(link.per_req_oe_b),
    .per_data_oe_b(link.per_data_oe_b));

  // Counts transfers and keeps the last words seen
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    prv_or <= ordy[0];
    if (prv_or) out_d <= link.data;
    if (ivl[0]) begin
      n_in <= n_in + 1;
      in_w <= iwd[0];
      gap <= cyc - last;
      last <= cyc;
    end
    if (ordy[0]) n_out <= n_out + 1;
    if (srdy) n_sent <= n_sent + 1;
    if (rvl) begin
      n_rcv <= n_rcv + 1;
      rcv_w <= rwd;
    end
    if (done[0]) n_done <= n_done + 1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick

  task automatic chk_cnt(input string nm, input int exp, input int got);
    total_checks++;
    if (exp != got) begin
      err_count++;
      $display("CHECK FAILED %s expected %0d seen %0d", nm, exp, got);
    end
  endtask : chk_cnt

  task automatic chk_word(input string nm, input logic [DATA_W-1:0] exp,
                          input logic [DATA_W-1:0] got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk_word

  task automatic chk_bit(input string nm, input logic exp, input logic got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %b seen %b", nm, exp, got);
    end
  endtask : chk_bit

  // Resets both ends, applies the configuration and issues go
  task automatic run(input logic per_drv);
    rst_b_i = 1'b0;
    tick(1);
    rst_b_i = 1'b1;
    cfg[0] = c;
    hs = c.hs_mode;
    dout = c.dir_out;
    dreq = per_drv;
    n_in = 0;
    n_out = 0;
    n_rcv = 0;
    n_done = 0;
    n_sent = 0;
    last = cyc;
    tick(2);
    go[0] = 1'b1;
    tick(1);
    go[0] = 1'b0;
  endtask : run

  task automatic wait_done();
    int k;
    k = 0;
    while (n_done == 0 && k < 3000) begin
      tick(1);
      k++;
    end
    chk_cnt("done pulses", 1, n_done);
  endtask : wait_done

  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
    tick(10);
  endtask : pulse

  task automatic sc_int_in();
    c = '0;
    c.int_req = 1'b1;
    c.interval = 16'h0002;
    c.buf_size = 16'h0003;
    c.width = WID_32;
    swd = 32'ha5c3_5a3c;
    // Port 3 belongs to the idle group, so its lane reads as zero
    pgrp = 4'h8;
    run(1'b0);
    // Loads the peripheral data word; the device keeps the request line
    pulse(rgo);
    wait_done();
    chk_cnt("input words", 3, n_in);
    chk_word("input word", 32'h00c3_5a3c, in_w);
    pgrp = 4'h0;
    chk_cnt("request period", 6, gap);
  endtask : sc_int_in

  task automatic sc_trig_out();
    c = '0;
    c.dir_out = 1'b1;
    c.int_req = 1'b1;
    c.interval = 16'h0002;
    c.start_en = 1'b1;
    c.buf_size = 16'h0002;
    c.width = WID_16;
    owd[0] = 32'h1234_5678;
    run(1'b0);
    tick(20);
    chk_cnt("words before trigger", 0, n_out);
    chk_bit("busy while armed", 1'b1, busy[0]);
    pulse(beg);
    wait_done();
    chk_cnt("output words", 2, n_out);
    chk_bit("busy after done", 1'b0, busy[0]);
    chk_word("output lanes", 32'h0000_5678, out_d);
  endtask : sc_trig_out

  task automatic sc_ext_stop();
    c = '0;
    c.stop_en = 1'b1;
    c.post_count = 16'h0002;
    c.buf_size = 16'h0064;
    c.width = WID_32;
    swd = 32'h0f1e_2d3c;
    run(1'b1);
    repeat (3) pulse(rgo);
    pulse(endp);
    pulse(rgo);
    chk_cnt("early done", 0, n_done);
    pulse(rgo);
    wait_done();
    chk_cnt("external words", 5, n_in);
  endtask : sc_ext_stop

  task automatic sc_pat_start();
    c = '0;
    c.int_req = 1'b1;
    c.interval = 16'h0002;
    c.start_en = 1'b1;
    c.start_pat = 1'b1;
    c.stop_en = 1'b1;
    c.stop_pat = 1'b1;
    c.post_count = 16'h0001;
    c.pattern = 32'h0000_0055;
    c.pmask = 32'h0000_00ff;
    c.buf_size = 16'h0001;
    c.width = WID_8;
    swd = 32'h0000_0000;
    run(1'b0);
    tick(20);
    chk_cnt("words before match", 0, n_in);
    swd = 32'h0000_0055;
    pulse(rgo);
    wait_done();
    chk_word("matched word", 32'h0000_0055, in_w);
    chk_cnt("words after stop match", 1, n_in);
  endtask : sc_pat_start

  task automatic sc_hs_in();
    c = '0;
    c.hs_mode = 1'b1;
    c.buf_size = 16'h0002;
    c.settle = 16'h0002;
    c.width = WID_32;
    swd = 32'hdead_beef;
    svl = 1'b1;
    run(1'b1);
    wait_done();
    svl = 1'b0;
    chk_cnt("handshake inputs", 2, n_in);
    chk_word("handshake input", 32'hdead_beef, in_w);
    chk_cnt("strobed words", 2, n_sent);
    chk_cnt("settle spacing", 1, int'(gap >= 7));
  endtask : sc_hs_in

  task automatic sc_hs_out();
    c = '0;
    c.hs_mode = 1'b1;
    c.dir_out = 1'b1;
    c.buf_size = 16'h0002;
    c.width = WID_8;
    owd[0] = 32'h7777_77c6;
    ovl[0] = 1'b1;
    wack = 1'b1;
    run(1'b1);
    wait_done();
    tick(10);
    chk_cnt("handshake outputs", 2, n_rcv);
    chk_word("handshake output", 32'h0000_00c6, rcv_w);
    chk_cnt("words taken", 2, n_out);
    chk_bit("peripheral idle", 1'b0, pbusy);
  endtask : sc_hs_out

  task automatic report_and_stop();
    $display("Checks made %0d, mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  initial begin
    rst_b_i = 1'b0;
    {cfg, c, go, owd, ovl, swd, pgrp} = '0;
    {hs, dout, wack, dreq, rgo, beg, endp, svl} = '0;
    {err_count, total_checks, cyc, last} = '0;
    repeat (2) @(posedge clk_i);
    #1;
    rst_b_i = 1'b1;
    tick(1);
    sc_int_in();
    sc_trig_out();
    sc_ext_stop();
    sc_pat_start();
    sc_hs_in();
    sc_hs_out();
    report_and_stop();
  end

  // Cuts a hang short well beyond the expected run length
  initial begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    report_and_stop();
  end
endmodule : tb_pattern_gen_handshake

// [logic/pgh_dev.sv]
// Two-group strobed pattern generation and compatible handshake engine
// Overview of operation
// - One data word moved per request pulse
// - Internal request low exactly one timebase period
// - Request period equals interval times timebase
// - External request low, high 20 ns; period 50 ns
// - No start trigger: start on software go
// - Stop trigger counts further transfers, then ends
// - No stop trigger: stop after buffer size words
// - Pattern match may replace start or stop
// - Triggers work for input and output
// - Acknowledge shows device ready; request shows peripheral
// - Optional settling delay between compatible transfers
// - Compatible mode supports 8, 16, 32 bits
// - Input: request is strobe, acknowledge is full
// - Input: ack low ready, high on fall, latch rise
// - Output: request is peripheral ack, acknowledge full
// - Output: ack low with data, data held stable
// - Output: ack off on fall, next after rise
// - Peripheral pulses request low for each word
// - Peripheral raises request after capture, may await
// - Request and settle timing from a 20 MHz timebase, or one 100 times slower with tb_slow
// - Two groups; ports assigned per group
module pgh_dev
  import pgh_pkg::*;
(
  input  wire logic                          clk_i,
  input  wire logic                          rst_b_i,
  pgh_link_if.dev                            link,
  input  wire pgh_cfg_s [NGRP-1:0]           cfg_i,
  input  wire logic [NPORT-1:0]              port_grp_i,
  input  wire logic [NGRP-1:0]               go_i,
  input  wire logic [NGRP-1:0][DATA_W-1:0]   out_word_i,
  input  wire logic [NGRP-1:0]               out_valid_i,
  output logic      [NGRP-1:0]               out_ready_o,
  output logic      [NGRP-1:0][DATA_W-1:0]   in_word_o,
  output logic      [NGRP-1:0]               in_valid_o,
  output logic      [NGRP-1:0]               busy_o,
  output logic      [NGRP-1:0]               done_o
);
  typedef struct packed {
    pgh_state_e        st;
    logic              rq1;
    logic              rq2;
    logic              rq3;
    logic              bt1;
    logic              bt2;
    logic              bt3;
    logic              et1;
    logic              et2;
    logic              et3;
    logic [CNT_W-1:0]  tb;
    logic [CNT_W-1:0]  ival;
    logic [CNT_W-1:0]  settle;
    logic [CNT_W-1:0]  xfer;
    logic [CNT_W-1:0]  post;
    logic              stopping;
    logic              req_low;
    logic              in_valid;
    logic              done;
    logic [DATA_W-1:0] dout;
    logic [DATA_W-1:0] din;
  } pgh_grp_s;

  typedef struct packed {
    pgh_grp_s [NGRP-1:0] g;
  } pgh_dev_s;

  localparam pgh_grp_s GRP_RST = '{st: ST_IDLE, rq1: 1'b1, rq2: 1'b1,
                                   rq3: 1'b1, default: '0};

  pgh_dev_s s;
  pgh_dev_s next_s;

  always_comb begin
    pgh_cfg_s          c;
    pgh_grp_s          o;
    pgh_grp_s          n;
    logic [DATA_W-1:0] wm;
    logic [DATA_W-1:0] bus;
    logic [CNT_W-1:0]  tlen;
    logic [NPORT-1:0]  lanes;
    logic              fall;
    logic              rise;
    logic              bt_hit;
    logic              et_hit;
    logic              match;
    logic              tick;
    logic              xfer;
    logic              last;
    logic              fin;
    c = '0;
    o = GRP_RST;
    n = GRP_RST;
    wm = '0;
    bus = '0;
    tlen = '0;
    lanes = '0;
    fall = 1'b0;
    rise = 1'b0;
    bt_hit = 1'b0;
    et_hit = 1'b0;
    match = 1'b0;
    tick = 1'b0;
    xfer = 1'b0;
    last = 1'b0;
    fin = 1'b0;
    next_s = s;
    out_ready_o = '0;
    for (int i = 0; i < NGRP; i++) begin
      c = cfg_i[i];
      o = s.g[i];
      n = o;
      n.rq1 = link.req[i];
      n.rq2 = o.rq1;
      n.rq3 = o.rq2;
      n.bt1 = link.begin_trigger[i];
      n.bt2 = o.bt1;
      n.bt3 = o.bt2;
      n.et1 = link.end_trigger[i];
      n.et2 = o.et1;
      n.et3 = o.et2;
      fall = o.rq3 & ~o.rq2;
      rise = ~o.rq3 & o.rq2;
      lanes = pgh_lanes(c.width);
      for (int p = 0; p < NPORT; p++) begin
        wm[p*PORT_W +: PORT_W] = {PORT_W{lanes[p] &
                                  (int'(port_grp_i[p]) == i)}};
      end
      bus = link.data & wm;
      match = ((bus ^ c.pattern) & c.pmask & wm) == '0;
      bt_hit = c.start_pat ? match : (o.bt2 & ~o.bt3);
      et_hit = c.stop_pat ? match : (o.et2 & ~o.et3);
      tlen = c.tb_slow ? TB_LEN_SLOW : TB_LEN_FAST;
      tick = o.tb == tlen - CNT_W'(1);
      n.tb = tick ? '0 : o.tb + CNT_W'(1);
      n.in_valid = 1'b0;
      n.done = 1'b0;
      xfer = 1'b0;
      case (o.st)
        ST_IDLE: begin
          if (tick) begin
            n.req_low = 1'b0;
          end
          if (go_i[i]) begin
            n.ival = '0;
            n.xfer = '0;
            n.post = '0;
            n.stopping = 1'b0;
            n.st = (!c.hs_mode && c.start_en) ? ST_ARM : ST_RUN;
          end
        end
        ST_ARM: begin
          if (bt_hit) begin
            n.st = ST_RUN;
          end
        end
        ST_RUN: begin
          if (c.hs_mode) begin
            if (c.dir_out) begin
              if (out_valid_i[i]) begin
                n.dout = out_word_i[i] & wm;
                out_ready_o[i] = 1'b1;
                n.st = ST_FULL;
              end
            end else if (fall) begin
              n.st = ST_WAIT;
            end
          end else begin
            if (c.int_req) begin
              if (tick) begin
                last = o.ival >= c.interval - CNT_W'(1);
                n.ival = last ? '0 : o.ival + CNT_W'(1);
                n.req_low = last;
                xfer = last;
              end
            end else begin
              xfer = fall;
            end
            if (c.stop_en && !o.stopping && et_hit) begin
              n.stopping = 1'b1;
            end
          end
        end
        ST_FULL: begin
          if (fall) begin
            n.st = ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (rise) begin
            xfer = 1'b1;
            n.settle = '0;
            n.st = ST_SETTLE;
          end
        end
        ST_SETTLE: begin
          if (o.settle >= c.settle) begin
            n.st = ST_RUN;
          end else if (tick) begin
            n.settle = o.settle + CNT_W'(1);
          end
        end
        default: begin
          n.st = ST_IDLE;
        end
      endcase
      if (xfer) begin
        if (!c.dir_out) begin
          n.din = bus;
          n.in_valid = 1'b1;
        end else if (!c.hs_mode) begin
          n.dout = out_word_i[i] & wm;
          out_ready_o[i] = 1'b1;
        end
        n.xfer = o.xfer + CNT_W'(1);
        if (n.stopping) begin
          n.post = o.post + CNT_W'(1);
        end
      end
      fin = (n.stopping && n.post >= c.post_count) ||
            (xfer && !(c.stop_en && !c.hs_mode) &&
             n.xfer >= c.buf_size);
      if (o.st != ST_IDLE && fin) begin
        n.st = ST_IDLE;
        n.done = 1'b1;
      end
      next_s.g[i] = n;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s <= {NGRP{GRP_RST}};
    end else begin
      s <= next_s;
    end
  end

  for (genvar g = 0; g < NGRP; g++) begin : g_out
    assign link.dev_req[g] = ~s.g[g].req_low;
    assign link.dev_req_oe_b[g] = ~(s.g[g].req_low ||
                                    (cfg_i[g].int_req && !cfg_i[g].hs_mode &&
                                     s.g[g].st != ST_IDLE));
    assign link.dev_ack[g] = ~((s.g[g].st == ST_RUN && cfg_i[g].hs_mode &&
                                !cfg_i[g].dir_out) ||
                               s.g[g].st == ST_FULL);
    assign in_word_o[g] = s.g[g].din;
    assign in_valid_o[g] = s.g[g].in_valid;
    assign done_o[g] = s.g[g].done;
    assign busy_o[g] = s.g[g].st != ST_IDLE;
  end

  for (genvar p = 0; p < NPORT; p++) begin : g_port
    logic [NPORT-1:0] p_lanes;
    assign p_lanes = pgh_lanes(cfg_i[port_grp_i[p]].width);
    assign link.dev_data[p] =
      s.g[port_grp_i[p]].dout[p*PORT_W +: PORT_W];
    assign link.dev_data_oe_b[p] =
      ~(cfg_i[port_grp_i[p]].dir_out &&
        p_lanes[p]);
  end
endmodule : pgh_dev

// [logic/pgh_link_if.sv]
// Link wires between the engine and the peripheral, with line resolution
interface pgh_link_if #(parameter int PGRP = 0);
  import pgh_pkg::*;
  logic [NGRP-1:0]              dev_req;
  logic [NGRP-1:0]              dev_req_oe_b;
  logic [NGRP-1:0]              dev_ack;
  logic [NPORT-1:0][PORT_W-1:0] dev_data;
  logic [NPORT-1:0]             dev_data_oe_b;
  logic                         per_req;
  logic                         per_req_oe_b;
  logic                         per_begin;
  logic                         per_end;
  logic [NPORT-1:0][PORT_W-1:0] per_data;
  logic [NPORT-1:0]             per_data_oe_b;
  logic [NGRP-1:0]              req;
  logic [NGRP-1:0]              begin_trigger;
  logic [NGRP-1:0]              end_trigger;
  logic                         grp_ack;
  logic [NPORT-1:0][PORT_W-1:0] data;

  // Request idles high, data idles low when nobody drives
  for (genvar g = 0; g < NGRP; g++) begin : g_grp
    assign req[g] = !dev_req_oe_b[g] ? dev_req[g] :
                    (g == PGRP && !per_req_oe_b) ? per_req : 1'b1;
    assign begin_trigger[g] = (g == PGRP) ? per_begin : 1'b0;
    assign end_trigger[g]   = (g == PGRP) ? per_end : 1'b0;
  end
  for (genvar p = 0; p < NPORT; p++) begin : g_port
    assign data[p] = !dev_data_oe_b[p] ? dev_data[p] :
                     !per_data_oe_b[p] ? per_data[p] : '0;
  end
  assign grp_ack = dev_ack[PGRP];

  modport dev (output dev_req, dev_req_oe_b, dev_ack, dev_data,
               dev_data_oe_b,
               input  req, begin_trigger, end_trigger, data);
  modport per (output per_req, per_req_oe_b, per_begin, per_end,
               per_data, per_data_oe_b,
               input  grp_ack, data);
endinterface : pgh_link_if

// [logic/pgh_per.sv]
// Peripheral end: external requests, triggers and compatible handshake
module pgh_per
  import pgh_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_b_i,
  pgh_link_if.per                link,
  input  wire logic              hs_mode_i,
  input  wire logic              dir_out_i,
  input  wire logic              wait_ack_i,
  input  wire logic              drive_req_i,
  input  wire logic              req_go_i,
  input  wire logic              begin_i,
  input  wire logic              end_i,
  input  wire logic [DATA_W-1:0] send_word_i,
  input  wire logic              send_valid_i,
  output logic                   send_ready_o,
  output logic      [DATA_W-1:0] rcv_word_o,
  output logic                   rcv_valid_o,
  output logic                   busy_o
);
  typedef struct packed {
    pgh_pstate_e       st;
    logic [3:0]        cnt;
    logic              req;
    logic              saw_hi;
    logic              bt;
    logic              et;
    logic              rcv_valid;
    logic [DATA_W-1:0] dout;
    logic [DATA_W-1:0] rcv;
  } pgh_per_s;

  localparam pgh_per_s PER_RST = '{st: PS_IDLE, req: 1'b1, default: '0};

  pgh_per_s s;
  pgh_per_s next_s;

  always_comb begin
    logic go_low;
    go_low = 1'b0;
    next_s = s;
    next_s.rcv_valid = 1'b0;
    next_s.bt = begin_i;
    next_s.et = end_i;
    send_ready_o = 1'b0;
    case (s.st)
      PS_IDLE: begin
        next_s.saw_hi = 1'b0;
        if (hs_mode_i) begin
          if (dir_out_i) begin
            if (!link.grp_ack) begin
              next_s.rcv = link.data;
              next_s.rcv_valid = 1'b1;
              go_low = 1'b1;
            end
          end else if (send_valid_i && !link.grp_ack) begin
            next_s.dout = send_word_i;
            send_ready_o = 1'b1;
            go_low = 1'b1;
          end
        end else if (req_go_i) begin
          if (dir_out_i) begin
            next_s.rcv = link.data;
            next_s.rcv_valid = 1'b1;
          end else begin
            next_s.dout = send_word_i;
            send_ready_o = send_valid_i;
          end
          go_low = 1'b1;
        end
        if (go_low) begin
          next_s.req = 1'b0;
          next_s.cnt = PER_LOW_LD;
          next_s.st = PS_LOW;
        end
      end
      PS_LOW: begin
        if (s.cnt != 4'h0) begin
          next_s.cnt = s.cnt - 4'h1;
        end else if (hs_mode_i && dir_out_i && wait_ack_i &&
                     !link.grp_ack) begin
          next_s.st = PS_HOLD;
        end else begin
          next_s.req = 1'b1;
          next_s.cnt = PER_HI_LD;
          next_s.st = PS_HIGH;
        end
      end
      PS_HOLD: begin
        if (link.grp_ack) begin
          next_s.req = 1'b1;
          next_s.cnt = PER_HI_LD;
          next_s.st = PS_HIGH;
        end
      end
      PS_HIGH: begin
        if (s.cnt != 4'h0) begin
          next_s.cnt = s.cnt - 4'h1;
        end else if (!hs_mode_i || s.saw_hi || link.grp_ack) begin
          next_s.st = PS_IDLE;
        end
      end
      default: begin
        next_s.st = PS_IDLE;
      end
    endcase
    if (s.st != PS_IDLE && link.grp_ack) begin
      next_s.saw_hi = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s <= PER_RST;
    end else begin
      s <= next_s;
    end
  end

  assign link.per_req = s.req;
  assign link.per_req_oe_b = ~drive_req_i;
  assign link.per_begin = s.bt;
  assign link.per_end = s.et;
  assign link.per_data = s.dout;
  assign link.per_data_oe_b = {NPORT{dir_out_i}};
  assign rcv_word_o = s.rcv;
  assign rcv_valid_o = s.rcv_valid;
  assign busy_o = s.st != PS_IDLE;
endmodule : pgh_per

// [logic/pgh_pkg.sv]
// Shared constants and types for the strobed pattern/handshake engine
package pgh_pkg;
  localparam int NGRP        = 2;
  localparam int NPORT       = 4;
  localparam int PORT_W      = 8;
  localparam int DATA_W      = NPORT * PORT_W;
  localparam int CNT_W       = 16;
  localparam int CLK_NS      = 20;
  // 20 MHz timebase
  localparam int TB_NS       = 50;
  localparam int TB_CYC      = (TB_NS + CLK_NS - 1) / CLK_NS;
  localparam int TB_SLOW_MUL = 100;
  localparam logic [CNT_W-1:0] TB_LEN_FAST = CNT_W'(TB_CYC);
  localparam logic [CNT_W-1:0] TB_LEN_SLOW = CNT_W'(TB_CYC * TB_SLOW_MUL);
  // External request pulse limits
  localparam int EXT_LOW_NS  = 20;
  localparam int EXT_HIGH_NS = 20;
  localparam int EXT_PER_NS  = 50;
  localparam int EXT_LOW_CYC = (EXT_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int EXT_HI_MIN  = (EXT_HIGH_NS + CLK_NS - 1) / CLK_NS;
  localparam int EXT_PER_CYC = (EXT_PER_NS + CLK_NS - 1) / CLK_NS;
  localparam int EXT_HI_CYC  = (EXT_PER_CYC - EXT_LOW_CYC > EXT_HI_MIN) ?
                               EXT_PER_CYC - EXT_LOW_CYC : EXT_HI_MIN;
  localparam logic [3:0] PER_LOW_LD = 4'(EXT_LOW_CYC - 1);
  localparam logic [3:0] PER_HI_LD  = 4'(EXT_HI_CYC - 1);
  // Data path width codes
  localparam logic [1:0] WID_8  = 2'h0;
  localparam logic [1:0] WID_16 = 2'h1;
  localparam logic [1:0] WID_32 = 2'h2;

  typedef enum logic [5:0] {
    ST_IDLE   = 6'h01,
    ST_ARM    = 6'h02,
    ST_RUN    = 6'h04,
    ST_FULL   = 6'h08,
    ST_WAIT   = 6'h10,
    ST_SETTLE = 6'h20
  } pgh_state_e;

  typedef enum logic [3:0] {
    PS_IDLE = 4'h1,
    PS_LOW  = 4'h2,
    PS_HOLD = 4'h4,
    PS_HIGH = 4'h8
  } pgh_pstate_e;

  typedef struct packed {
    logic              hs_mode;
    logic              dir_out;
    logic              int_req;
    logic              tb_slow;
    logic [CNT_W-1:0]  interval;
    logic              start_en;
    logic              start_pat;
    logic              stop_en;
    logic              stop_pat;
    logic [DATA_W-1:0] pattern;
    logic [DATA_W-1:0] pmask;
    logic [CNT_W-1:0]  post_count;
    logic [CNT_W-1:0]  buf_size;
    logic [CNT_W-1:0]  settle;
    logic [1:0]        width;
  } pgh_cfg_s;

  function automatic logic [NPORT-1:0] pgh_lanes(input logic [1:0] w);
    if (w == WID_8) begin
      return 4'h1;
    end else if (w == WID_16) begin
      return 4'h3;
    end
    return 4'hf;
  endfunction : pgh_lanes
endpackage : pgh_pkg
